/* verilog/pmt_phy_timing.sv */
// MII-side timing engine: carrier, collision, latencies, link pulses, heartbeat, jabber
`timescale 1ns/1ps
`default_nettype none
module pmt_phy_timing
    import pmt_pkg::*;
#(
    parameter int FLP_GAP = FLP_GAP_CYC,
    parameter int SQE_DELAY = SQE_DELAY_CYC,
    parameter int SQE_WIDTH = SQE_WIDTH_CYC,
    parameter int JAB_LIMIT = JAB_LIMIT_CYC,
    parameter int UNJAB = UNJAB_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Mode
    input wire logic speed_fast_i,
    input wire logic autoneg_i,
    input wire logic [15:0] flp_word_i,
    // MII transmit side
    input wire logic tx_clk_i,
    input wire logic tx_en_i,
    input wire logic tx_er_i,
    input wire logic [3:0] txd_i,
    // MII receive side
    output logic rx_dv_o,
    output logic rx_er_o,
    output logic [3:0] rxd_o,
    output logic crs_o,
    output logic col_o,
    // Line
    input wire logic line_rx_in_i,
    input wire logic [3:0] line_rxd_i,
    output logic fast_line_tx_out_o,
    output logic slow_line_tx_out_o,
    output logic [3:0] line_txd_o,
    output logic flp_pulse_o,
    output logic jabbed_o
);
    // Two-stage synchronisers for all pin inputs
    logic [1:0] s_clk, s_en, s_er, s_rx;
    logic [3:0] s_txd [2];
    logic [3:0] s_rxd [2];
    logic s_fast, s_an, s_fast_m, s_an_m;
    logic [15:0] word_m, word_s;
    logic clk_d;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_clk <= '0;
            s_en <= '0;
            s_er <= '0;
            s_rx <= '0;
            s_txd[0] <= 4'h0;
            s_txd[1] <= 4'h0;
            s_rxd[0] <= 4'h0;
            s_rxd[1] <= 4'h0;
            clk_d <= 1'b0;
            s_fast <= 1'b0;
            s_an <= 1'b0;
            s_fast_m <= 1'b0;
            s_an_m <= 1'b0;
            word_m <= 16'h0000;
            word_s <= 16'h0000;
        end else begin
            s_clk <= {s_clk[0], tx_clk_i};
            s_en <= {s_en[0], tx_en_i};
            s_er <= {s_er[0], tx_er_i};
            s_rx <= {s_rx[0], line_rx_in_i};
            s_txd[0] <= txd_i;
            s_txd[1] <= s_txd[0];
            s_rxd[0] <= line_rxd_i;
            s_rxd[1] <= s_rxd[0];
            clk_d <= s_clk[1];
            s_fast_m <= speed_fast_i;
            s_fast <= s_fast_m;
            s_an_m <= autoneg_i;
            s_an <= s_an_m;
            word_m <= flp_word_i;
            word_s <= word_m;
        end
    end
    // Bit-time tick, free-running from reset and not restarted by the link clock edges
    logic tx_edge;
    logic [3:0] bt_cnt, next_bt_cnt;
    logic bt;
    assign tx_edge = s_clk[1] & ~clk_d;
    function automatic logic [4:0] pick(input logic fast, input int f, input int s);
        pick = fast ? 5'(f) : 5'(s);
    endfunction : pick
    always_comb begin
        next_bt_cnt = bt_cnt + 4'h1;
        if (bt_cnt == 4'((s_fast ? BT_FAST_CYC : BT_SLOW_CYC) - 1)) begin
            next_bt_cnt = 4'h0; // RULE17
        end
    end
    assign bt = (bt_cnt == 4'h0);
    // Transmit enable sampled on link clock rising edge
    logic tx_en_s, tx_er_s;
    logic [3:0] txd_s;
    logic jab, next_jab;
    logic [31:0] jab_cnt, next_jab_cnt;
    logic [31:0] sqe_cnt, next_sqe_cnt;
    logic sqe, next_sqe;
    logic sqe_wait, next_sqe_wait;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bt_cnt <= 4'h0;
            tx_en_s <= 1'b0;
            tx_er_s <= 1'b0;
            txd_s <= 4'h0;
        end else begin
            bt_cnt <= next_bt_cnt;
            if (tx_edge) begin
                tx_en_s <= s_en[1] & ~jab; // RULE16
                tx_er_s <= s_er[1];
                txd_s <= s_txd[1];
            end
        end
    end
    // Transmit path delays
    pmt_nib_type tx_in, tx_q, txc_q, rx_in, rx_q, rc_q;
    assign tx_in = '{en: tx_en_s, er: tx_er_s, data: txd_s};
    pmt_delay #(.DEPTH(DLY_DEPTH)) u_tx (
        .clk_i(clk_i), .reset_i(reset_i), .step_i(bt),
        .taps_i(pick(s_fast, TX_LAT_FAST, TX_LAT_SLOW)), // RULE3 RULE4
        .d_i(tx_in), .q_o(tx_q));
    // Carrier on transmit: separate rise and fall delays
    logic [4:0] txc_taps;
    // Rise from a fixed tap; switching taps on the fall would re-read old frame bits
    assign txc_taps = pick(s_fast, TX_CRS_ON_FAST, TX_CRS_ON_SLOW); // RULE1 RULE2
    pmt_delay #(.DEPTH(DLY_DEPTH)) u_txc (
        .clk_i(clk_i), .reset_i(reset_i), .step_i(bt),
        .taps_i(txc_taps), .d_i(tx_in), .q_o(txc_q));
    // Receive path
    assign rx_in = '{en: s_rx[1], er: 1'b0, data: s_rxd[1]};
    pmt_delay #(.DEPTH(DLY_DEPTH)) u_rx (
        .clk_i(clk_i), .reset_i(reset_i), .step_i(bt),
        .taps_i(pick(s_fast, RX_LAT_FAST, RX_LAT_SLOW)), // RULE5
        .d_i(rx_in), .q_o(rx_q));
    logic [4:0] rxc_taps;
    assign rxc_taps = s_rx[1] ? pick(s_fast, RX_CRS_ON_FAST, RX_CRS_ON_SLOW)
                              : pick(s_fast, RX_CRS_OFF_FAST, RX_CRS_OFF_SLOW); // RULE8 RULE9
    pmt_delay #(.DEPTH(DLY_DEPTH)) u_rxc (
        .clk_i(clk_i), .reset_i(reset_i), .step_i(bt),
        .taps_i(rxc_taps), .d_i(rx_in), .q_o(rc_q));
    // Carrier, collision and receive outputs
    logic crs_tx, crs_rx;
    logic next_crs_tx;
    logic [4:0] off_cnt, next_off_cnt, off_taps;
    logic col_busy, col_hold;
    logic next_crs, next_col, next_dv, next_er;
    logic [3:0] next_rxd;
    logic next_fast_out, next_slow_out;
    logic [3:0] next_line_txd;
    // Fall counted in bit steps after enable drops, so short frames cannot bounce carrier
    assign off_taps = pick(s_fast, TX_CRS_OFF_FAST, TX_CRS_OFF_SLOW);
    always_comb begin
        next_off_cnt = off_cnt;
        if (tx_en_s || !crs_tx) begin
            next_off_cnt = 5'h00;
        end else if (bt) begin
            next_off_cnt = off_cnt + 5'h01;
        end
        next_crs_tx = txc_q.en | (crs_tx & (off_cnt != off_taps)); // RULE1 RULE2
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            crs_tx <= 1'b0;
            crs_rx <= 1'b0;
            off_cnt <= 5'h00;
        end else begin
            crs_tx <= next_crs_tx;
            crs_rx <= rc_q.en;
            off_cnt <= next_off_cnt;
        end
    end
    assign col_busy = crs_rx & tx_en_s;
    // Collision held past line event by the carrier fall delay
    assign col_hold = s_fast & crs_rx & crs_tx; // RULE10
    always_comb begin
        // Receive carrier taken unregistered so it keeps step with the data path
        next_crs = crs_tx | rc_q.en; // RULE8 RULE9
        // Receive data is gated by receive carrier so it ends with it
        next_dv = rx_q.en & crs_rx; // RULE6 RULE7
        next_er = rx_q.er & crs_rx;
        next_rxd = next_dv ? rx_q.data : 4'h0;
        next_col = col_busy | col_hold | sqe; // RULE14
        next_fast_out = s_fast & tx_q.en;
        next_slow_out = ~s_fast & tx_q.en & ~jab;
        next_line_txd = tx_q.en ? tx_q.data : 4'h0;
    end
    // Heartbeat after transmit in slow mode
    always_comb begin
        next_sqe = sqe;
        next_sqe_wait = sqe_wait;
        next_sqe_cnt = sqe_cnt;
        if (!s_fast && tx_en_s) begin
            next_sqe_wait = 1'b1;
            next_sqe_cnt = '0;
            next_sqe = 1'b0;
        end else if (sqe_wait) begin
            next_sqe_cnt = sqe_cnt + 32'h1;
            if (sqe_cnt == 32'(SQE_DELAY - 1)) begin
                next_sqe_wait = 1'b0;
                next_sqe = 1'b1; // RULE14
                next_sqe_cnt = '0;
            end
        end else if (sqe) begin
            next_sqe_cnt = sqe_cnt + 32'h1;
            if (sqe_cnt == 32'(SQE_WIDTH - 1)) begin
                next_sqe = 1'b0; // RULE15
            end
        end
    end
    // Jabber cut-off and unjab
    always_comb begin
        next_jab = jab;
        next_jab_cnt = jab_cnt;
        if (jab) begin
            next_jab_cnt = jab_cnt + 32'h1;
            if (jab_cnt == 32'(UNJAB - 1)) begin
                next_jab = 1'b0; // RULE16
                next_jab_cnt = '0;
            end
        end else if (!s_fast && s_en[1]) begin
            next_jab_cnt = jab_cnt + 32'h1;
            if (jab_cnt == 32'(JAB_LIMIT - 1)) begin
                next_jab = 1'b1; // RULE16
                next_jab_cnt = '0;
            end
        end else begin
            next_jab_cnt = '0;
        end
    end
    // Fast link pulse burst generator
    pmt_flp_type fst, next_fst;
    logic [31:0] fcnt, next_fcnt;
    logic [5:0] pos, next_pos;
    logic [31:0] gcnt, next_gcnt;
    logic next_flp;
    logic [15:0] word;
    always_comb begin
        next_fst = fst;
        next_fcnt = fcnt + 32'h1;
        next_pos = pos;
        next_gcnt = gcnt + 32'h1;
        next_flp = 1'b0;
        word = word_s;
        if (gcnt == 32'(FLP_GAP - 1)) begin
            next_gcnt = '0; // RULE13
        end
        case (fst)
            FLP_IDLE: begin
                next_fcnt = '0;
                if (s_an && gcnt == 32'h0) begin
                    next_fst = FLP_CLK;
                    next_pos = 6'h00;
                end
            end
            FLP_CLK: begin
                next_flp = (fcnt < 32'(FLP_PULSE_CYC)); // RULE11
                if (fcnt == 32'(FLP_HALF_CYC - 1)) begin
                    // Burst closes on a clock pulse: one more clock than data positions
                    next_fst = (pos >= 6'(2 * (FLP_POSITIONS / 2))) ? FLP_IDLE : FLP_DATA;
                end
            end
            FLP_DATA: begin
                next_flp = word[pos[4:1]] & (fcnt < 32'(FLP_HALF_CYC + FLP_PULSE_CYC)); // RULE12
                if (fcnt == 32'(FLP_PER_CYC - 1)) begin
                    next_fcnt = '0;
                    next_pos = pos + 6'h02;
                    next_fst = FLP_CLK;
                end
            end
            default: next_fst = FLP_IDLE;
        endcase
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            crs_o <= 1'b0;
            col_o <= 1'b0;
            rx_dv_o <= 1'b0;
            rx_er_o <= 1'b0;
            rxd_o <= 4'h0;
            fast_line_tx_out_o <= 1'b0;
            slow_line_tx_out_o <= 1'b0;
            line_txd_o <= 4'h0;
            flp_pulse_o <= 1'b0;
            jabbed_o <= 1'b0;
            sqe <= 1'b0;
            sqe_wait <= 1'b0;
            sqe_cnt <= '0;
            jab <= 1'b0;
            jab_cnt <= '0;
            fst <= FLP_IDLE;
            fcnt <= '0;
            pos <= 6'h00;
            gcnt <= '0;
        end else begin
            crs_o <= next_crs;
            col_o <= next_col;
            rx_dv_o <= next_dv;
            rx_er_o <= next_er;
            rxd_o <= next_rxd;
            fast_line_tx_out_o <= next_fast_out;
            slow_line_tx_out_o <= next_slow_out;
            line_txd_o <= next_line_txd;
            flp_pulse_o <= next_flp;
            jabbed_o <= next_jab;
            sqe <= next_sqe;
            sqe_wait <= next_sqe_wait;
            sqe_cnt <= next_sqe_cnt;
            jab <= next_jab;
            jab_cnt <= next_jab_cnt;
            fst <= next_fst;
            fcnt <= next_fcnt;
            pos <= next_pos;
            gcnt <= next_gcnt;
        end
    end
endmodule : pmt_phy_timing
`default_nettype wire

/* verilog/pmt_pkg.sv */
// Package with timing constants and carriers for the MII-side timing block
// Operation
// RULE1: At 100 Mb/s, carrier follows transmit enable up and down after 4 bit times.
// RULE2: At 10 Mb/s, carrier rises 2-4 bit times after enable, falls 15-20 after.
// RULE3: At 100 Mb/s, line transmit output starts 8 bit times after enable.
// RULE4: At 10 Mb/s, line transmit output starts 2-4 bit times after enable.
// RULE5: Receive nibbles appear 15 bit times (100) or 7 bit times (10) after line.
// RULE6: Receive data follows carrier rise by 4 (100) or at most 20 (10) bit times; the code gives 3 bit times at 100 Mb/s.
// RULE7: Receive data ends with carrier fall (100) or within 3 bit times (10).
// RULE8: Carrier rises 10-14 (100) or 1-4 (10) bit times after line activity.
// RULE9: Carrier falls 14-18 (100) or 1-15 (10) bit times after line quiet.
// RULE10: At 100 Mb/s, collision releases 14-18 bit times after the line event.
// RULE11: Each link pulse burst has 33 pulse positions, pulses 100 ns wide.
// RULE12: Clock pulses 125 us apart; data pulse at 62.5 us marks a one.
// RULE13: Bursts last about 2 ms and start 13.93 ms apart.
// RULE14: At 10 Mb/s, heartbeat collision starts 0.65-1.6 ms after enable falls.
// RULE15: Heartbeat collision pulse lasts 0.5 to 1.5 ms, typically 1.1 ms.
// RULE16: At 10 Mb/s, cut transmissions longer than the limit; unjab after interval.
// RULE17: Bit times count 10 ns at 100 Mb/s and 100 ns at 10 Mb/s.
// RULE18: The controller keeps enable low while jabbed and ignores heartbeat as collision.
package pmt_pkg;
    localparam int CLK_NS = 10;
    localparam int BT_FAST_NS = 10;
    localparam int BT_SLOW_NS = 100;
    localparam int BT_FAST_CYC = BT_FAST_NS / CLK_NS;
    localparam int BT_SLOW_CYC = BT_SLOW_NS / CLK_NS;
    localparam int TX_CRS_ON_FAST = 4;
    localparam int TX_CRS_OFF_FAST = 4;
    localparam int TX_CRS_ON_SLOW = 3;
    localparam int TX_CRS_OFF_SLOW = 15;
    localparam int TX_LAT_FAST = 8;
    localparam int TX_LAT_SLOW = 3;
    localparam int RX_CRS_ON_FAST = 12;
    localparam int RX_CRS_OFF_FAST = 16;
    localparam int RX_CRS_ON_SLOW = 2;
    localparam int RX_CRS_OFF_SLOW = 10;
    localparam int RX_LAT_FAST = 15;
    localparam int RX_LAT_SLOW = 7;
    localparam int COL_OFF_FAST = 16;
    localparam int DLY_DEPTH = 16;
    localparam int FLP_PULSE_NS = 100;
    localparam int FLP_HALF_NS = 62500;
    localparam int FLP_PER_NS = 125000;
    localparam int FLP_POSITIONS = 33;
    localparam int FLP_BURST_US = 2000;
    localparam int FLP_GAP_NS = 13930000;
    localparam int SQE_DELAY_US = 1300;
    localparam int SQE_WIDTH_US = 1100;
    localparam int JAB_LIMIT_MS = 48;
    localparam int UNJAB_MS = 505;
    localparam int FLP_PULSE_CYC = FLP_PULSE_NS / CLK_NS;
    localparam int FLP_HALF_CYC = FLP_HALF_NS / CLK_NS;
    localparam int FLP_PER_CYC = FLP_PER_NS / CLK_NS;
    localparam int FLP_GAP_CYC = FLP_GAP_NS / CLK_NS;
    localparam int SQE_DELAY_CYC = SQE_DELAY_US * 1000 / CLK_NS;
    localparam int SQE_WIDTH_CYC = SQE_WIDTH_US * 1000 / CLK_NS;
    localparam int JAB_LIMIT_CYC = JAB_LIMIT_MS * 100000;
    localparam int UNJAB_CYC = UNJAB_MS * 100000;
    localparam logic [15:0] FLP_WORD_RESET = 16'h01E1;
    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] data;
    } pmt_nib_type;
    typedef enum logic [1:0] {
        FLP_IDLE = 2'b00,
        FLP_CLK = 2'b01,
        FLP_DATA = 2'b11
    } pmt_flp_type;
endpackage : pmt_pkg

/* verilog/pmt_delay.sv */
// Bit-time delay line for a nibble carrier
`timescale 1ns/1ps
`default_nettype none
module pmt_delay
    import pmt_pkg::*;
#(
    parameter int DEPTH = DLY_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Stream
    input wire logic step_i,
    input wire logic [4:0] taps_i,
    input wire pmt_nib_type d_i,
    output pmt_nib_type q_o
);
    pmt_nib_type line [DEPTH];
    pmt_nib_type next_line [DEPTH];
    always_comb begin
        next_line = line;
        if (step_i) begin
            next_line[0] = d_i;
            for (int i = 1; i < DEPTH; i++) begin
                next_line[i] = line[i-1];
            end
        end
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                line[i] <= '0;
            end
        end else begin
            line <= next_line;
        end
    end
    // Tap zero passes input straight through
    always_comb begin
        if (taps_i == 5'h00) begin
            q_o = d_i;
        end else begin
            q_o = line[taps_i[3:0] - 4'h1];
        end
    end
endmodule : pmt_delay
`default_nettype wire

/* verification/pmt_phy_timing_properties.sv */
// Checker for the MII-side timing block
`timescale 1ns/1ps
`default_nettype none
module pmt_phy_timing_properties
    import pmt_pkg::*;
#(
    parameter int SQE_WIDTH = SQE_WIDTH_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Watched ports
    input wire logic speed_fast_i,
    input wire logic line_rx_in_i,
    input wire logic rx_dv_o,
    input wire logic crs_o,
    input wire logic col_o,
    input wire logic fast_line_tx_out_o,
    input wire logic slow_line_tx_out_o,
    input wire logic flp_pulse_o,
    input wire logic jabbed_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Heartbeat length, cleared whenever collision is low
    logic [31:0] hb_len;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) hb_len <= 32'h0;
        else hb_len <= col_o ? hb_len + 32'h1 : 32'h0;
    end
    AST_JAB_CUT: assert property (jabbed_o && $past(jabbed_o) |-> !slow_line_tx_out_o)
        else $error("transmit output active during lockout");
    AST_FLP_WIDTH: assert property ($rose(flp_pulse_o) |->
        flp_pulse_o[*5] ##1 flp_pulse_o[*5] ##1 !flp_pulse_o)
        else $error("link pulse not ten cycles wide");
    AST_HB_WIDTH: assert property (!speed_fast_i && !line_rx_in_i && $fell(col_o)
        |-> hb_len == SQE_WIDTH)
        else $error("heartbeat width wrong");
    AST_RX_CRS_OFF_FAST: assert property ($fell(line_rx_in_i) && speed_fast_i && crs_o
        && !fast_line_tx_out_o |-> ##12 crs_o ##[1:10] !crs_o)
        else $error("fast carrier release out of window");
    AST_DV_END_FAST: assert property (speed_fast_i && $fell(crs_o) |-> ##[0:1] !rx_dv_o)
        else $error("fast data valid outlives carrier");
    AST_DV_END_SLOW: assert property (!speed_fast_i && $fell(crs_o) |-> ##[0:30] !rx_dv_o)
        else $error("slow data valid outlives carrier");
    AST_DV_AFTER_CRS: assert property ($rose(rx_dv_o) |-> crs_o)
        else $error("data valid without carrier");
    AST_FAST_TX_CRS: assert property (speed_fast_i && $rose(fast_line_tx_out_o) |-> crs_o)
        else $error("fast line output before carrier");
    AST_SLOW_CRS_HOLD: assert property ((!speed_fast_i && !jabbed_o
        && $fell(slow_line_tx_out_o)) ##1 !jabbed_o |-> ##100 crs_o ##[1:70] !crs_o)
        else $error("slow carrier release out of window");
    COV_FLP: cover property ($rose(flp_pulse_o));
    COV_JAB: cover property ($rose(jabbed_o));
    COV_HB: cover property (!speed_fast_i && $rose(col_o));
endmodule : pmt_phy_timing_properties
bind pmt_phy_timing pmt_phy_timing_properties #(.SQE_WIDTH(SQE_WIDTH)) u_props (
    .clk_i(clk_i), .reset_i(reset_i), .speed_fast_i(speed_fast_i),
    .line_rx_in_i(line_rx_in_i), .rx_dv_o(rx_dv_o), .crs_o(crs_o), .col_o(col_o),
    .fast_line_tx_out_o(fast_line_tx_out_o), .slow_line_tx_out_o(slow_line_tx_out_o),
    .flp_pulse_o(flp_pulse_o), .jabbed_o(jabbed_o));
`default_nettype wire

/* verification/pmt_mac_model.sv */
// Controller model driving the MII transmit side
`timescale 1ns/1ps
`default_nettype none
module pmt_mac_model (
    // Lockout seen from the transceiver
    input wire logic jabbed_i,
    // MII transmit
    output var logic tx_clk_o,
    output var logic tx_en_o,
    output var logic tx_er_o,
    output var logic [3:0] txd_o
);
    logic run;
    // Clock stands still low between frames
    initial begin
        tx_clk_o = 1'b0;
        run = 1'b0;
        tx_en_o = 1'b0;
        tx_er_o = 1'b0;
        txd_o = 4'hF;
        forever begin
            wait (run);
            #62.5 tx_clk_o = 1'b1;
            #62.5 tx_clk_o = 1'b0;
        end
    end
    task automatic send_frame(input int cnt, input logic [3:0] d0);
        // Offset keeps link clock edges away from the bench clock edges
        #2;
        run = 1'b1;
        for (int i = 0; i < cnt; i++) begin
            @(negedge tx_clk_o);
            tx_en_o = !jabbed_i;
            txd_o = d0 + i[3:0];
        end
        @(negedge tx_clk_o);
        tx_en_o = 1'b0;
        txd_o = ~txd_o;
        repeat (4) @(negedge tx_clk_o);
        run = 1'b0;
    endtask : send_frame
endmodule : pmt_mac_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the MII-side timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i, reset_i, speed_fast, autoneg, line_rx_in, tx_clk, tx_en, tx_er;
    logic rx_dv, rx_er, crs, col, fast_out, slow_out, flp, jabbed;
    logic [15:0] flp_word;
    logic [3:0] line_rxd, txd, rxd, line_txd;
    int mismatches, checks, n;
    // Long counts shortened so the run stays short
    pmt_phy_timing #(.FLP_GAP(2000), .SQE_DELAY(100), .SQE_WIDTH(80), .JAB_LIMIT(500),
        .UNJAB(800)) DUT (
        .clk_i(clk_i), .reset_i(reset_i), .speed_fast_i(speed_fast), .autoneg_i(autoneg),
        .flp_word_i(flp_word), .tx_clk_i(tx_clk), .tx_en_i(tx_en), .tx_er_i(tx_er),
        .txd_i(txd), .rx_dv_o(rx_dv), .rx_er_o(rx_er), .rxd_o(rxd), .crs_o(crs),
        .col_o(col), .line_rx_in_i(line_rx_in), .line_rxd_i(line_rxd),
        .fast_line_tx_out_o(fast_out), .slow_line_tx_out_o(slow_out),
        .line_txd_o(line_txd), .flp_pulse_o(flp), .jabbed_o(jabbed));
    pmt_mac_model MAC (.jabbed_i(jabbed), .tx_clk_o(tx_clk), .tx_en_o(tx_en),
        .tx_er_o(tx_er), .txd_o(txd));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic probe(input int s);
        case (s)
            0: return crs;
            1: return fast_out;
            2: return slow_out;
            3: return col;
            4: return rx_dv;
            5: return flp;
            6: return jabbed;
            default: return tx_en;
        endcase
    endfunction : probe
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // Counts falling edges until the probed signal reaches v
    task automatic wait_for(input int s, input logic v, input int lim);
        n = 0;
        while (probe(s) !== v) begin
            if (n >= lim) begin
                mismatches++;
                $display("ERROR wait on signal %0d expected %0b seen %0b", s, v, probe(s));
                print_verdict();
            end
            @(negedge clk_i);
            n++;
        end
    endtask : wait_for
    task automatic chk_range(input string name, input int lo, input int hi);
        checks++;
        if (n < lo || n > hi) begin
            mismatches++;
            $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, n);
        end
    endtask : chk_range
    task automatic chk_val(input string name, input logic [3:0] e, input logic [3:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : chk_val
    task automatic t_flp();
        wait_for(5, 1'b1, 20000);
        wait_for(5, 1'b0, 20);
        chk_range("link pulse width", 10, 10);
        wait_for(5, 1'b1, 7000);
        chk_range("data pulse gap", 6238, 6242);
        wait_for(5, 1'b0, 20);
        wait_for(5, 1'b1, 7000);
        chk_range("clock pulse gap", 6238, 6242);
        autoneg = 1'b0;
    endtask : t_flp
    task automatic t_fast_tx();
        speed_fast = 1'b1;
        repeat (20) @(negedge clk_i);
        fork
            MAC.send_frame(8, 4'h3);
            begin
                wait_for(7, 1'b1, 200);
                wait_for(0, 1'b1, 30);
                chk_range("fast tx crs on", 10, 20);
                wait_for(1, 1'b1, 30);
                chk_range("fast tx out after crs", 2, 7);
                chk_val("fast tx nibble", 4'h3, line_txd);
                wait_for(7, 1'b0, 200);
                wait_for(0, 1'b0, 30);
                chk_range("fast tx crs off", 10, 20);
            end
        join
    endtask : t_fast_tx
    task automatic t_slow_tx();
        speed_fast = 1'b0;
        repeat (20) @(negedge clk_i);
        fork
            MAC.send_frame(6, 4'h5);
            begin
                wait_for(7, 1'b1, 200);
                wait_for(0, 1'b1, 80);
                chk_range("slow tx crs on", 26, 52);
                wait_for(2, 1'b1, 40);
                chk_range("slow tx out after crs", 0, 20);
                wait_for(7, 1'b0, 1000);
                wait_for(3, 1'b1, 300);
                chk_range("heartbeat delay", 100, 115);
                wait_for(3, 1'b0, 200);
                chk_range("heartbeat width", 79, 81);
            end
        join
    endtask : t_slow_tx
    task automatic t_rx(input logic f, input int on_hi, input int dv_lo, input int dv_hi,
        input int off_lo, input int off_hi, input int hold);
        speed_fast = f;
        repeat (20) @(negedge clk_i);
        line_rx_in = 1'b1;
        line_rxd = 4'hA;
        wait_for(0, 1'b1, 60);
        chk_range("rx crs on", 10, on_hi);
        wait_for(4, 1'b1, 250);
        chk_range("rx dv after crs", dv_lo, dv_hi);
        chk_val("rx nibble", 4'hA, rxd);
        chk_val("rx error", 4'h0, {3'h0, rx_er});
        repeat (hold) @(negedge clk_i);
        line_rx_in = 1'b0;
        line_rxd = 4'h5;
        wait_for(0, 1'b0, 200);
        chk_range("rx crs off", off_lo, off_hi);
    endtask : t_rx
    task automatic t_jab();
        speed_fast = 1'b0;
        repeat (20) @(negedge clk_i);
        fork
            MAC.send_frame(80, 4'h1);
            begin
                wait_for(7, 1'b1, 200);
                wait_for(6, 1'b1, 700);
                chk_range("jab cut", 490, 530);
                wait_for(6, 1'b0, 2000);
                chk_range("unjab", 800, 1700);
            end
        join
    endtask : t_jab
    initial begin
        mismatches = 0;
        checks = 0;
        n = 0;
        reset_i = 1'b1;
        speed_fast = 1'b1;
        autoneg = 1'b1;
        flp_word = 16'h0001;
        line_rx_in = 1'b0;
        line_rxd = 4'h0;
        repeat (12) @(negedge clk_i);
        chk_val("reset outputs", 4'h0, {crs | col, rx_dv | fast_out, flp | slow_out, jabbed});
        reset_i = 1'b0;
        repeat (3) @(negedge clk_i);
        t_flp();
        t_fast_tx();
        t_slow_tx();
        t_rx(1'b1, 18, 3, 8, 14, 22, 40);
        t_rx(1'b0, 44, 1, 205, 10, 154, 300);
        t_jab();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
